// >>> rtl/iobdc_device.sv
// device end of the i/o bus: select decode, command strobes, control/status/data words
module iobdc_device #(
  parameter logic [iobdc_pkg::SEL_W-1:0] DEV_NUM_CTL = iobdc_pkg::USER_DEV_MIN, // control/status number
  parameter logic [iobdc_pkg::SEL_W-1:0] DEV_NUM_DATA = 7'h41 // data number
) (
  input wire logic clk, // 40 mhz
  input wire logic rst_n, // async, active low
  iobdc_bus_if.dev bus, // processor side
  output logic [iobdc_pkg::DATA_W-1:0] out_word, // last data-out word
  output logic out_valid, // one-cycle pulse, new out_word
  input wire logic out_taken, // pulse: output finished, sets done
  input wire logic [iobdc_pkg::DATA_W-1:0] in_word, // input word from user logic
  input wire logic in_ready, // pulse: in_word valid, sets done
  input wire logic err_event, // pulse: error condition
  output logic run, // control bit for user logic
  output logic readin_start // one-cycle pulse, read-in requested
);
  typedef struct packed {
    logic [iobdc_pkg::CMD_W-1:0] c1;
    logic [iobdc_pkg::CMD_W-1:0] c2;
    logic [iobdc_pkg::CMD_W-1:0] c3;
    logic [iobdc_pkg::SEL_W-1:0] o1;
    logic [iobdc_pkg::SEL_W-1:0] z1;
    logic [iobdc_pkg::SEL_W-1:0] o2;
    logic [iobdc_pkg::SEL_W-1:0] z2;
    logic [iobdc_pkg::DATA_W-1:0] d1;
    logic [iobdc_pkg::DATA_W-1:0] d2;
    logic [iobdc_pkg::HALF_W-1:0] ctl;
    logic [iobdc_pkg::DATA_W-1:0] out_reg;
    logic [iobdc_pkg::DATA_W-1:0] in_reg;
    logic [iobdc_pkg::DATA_W-1:0] dout;
    logic oe;
    logic out_valid;
    logic busy;
    logic done;
    logic err;
    logic readin;
    logic readin_start;
    logic rdi_data;
    logic [iobdc_pkg::PI_W-1:0] pi;
  } iobdc_dev_state_t;

  iobdc_dev_state_t q;
  iobdc_dev_state_t next_q;

  // one input of the seven-way and per pair: the true line for a one, the complement for a zero
  function automatic logic iobdc_match(input logic [iobdc_pkg::SEL_W-1:0] num,
                                       input logic [iobdc_pkg::SEL_W-1:0] one,
                                       input logic [iobdc_pkg::SEL_W-1:0] zero);
    logic [iobdc_pkg::SEL_W-1:0] term;
    term = (num & one) | (~num & zero);
    return &term;
  endfunction : iobdc_match

  // channel decoder, output 0 unused so channel zero never requests
  function automatic logic [iobdc_pkg::PI_W-1:0] iobdc_pi_dec(input logic [iobdc_pkg::CH_W-1:0] ch,
                                                              input logic cond);
    logic [iobdc_pkg::PI_W:0] hot;
    hot = '0;
    hot[ch] = cond;
    return hot[iobdc_pkg::PI_W:1];
  endfunction : iobdc_pi_dec

  logic sel_ctl;
  logic sel_dat;
  logic [iobdc_pkg::CMD_W-1:0] strobe;
  logic [iobdc_pkg::CMD_W-1:0] s_ctl;
  logic [iobdc_pkg::CMD_W-1:0] s_dat;
  logic [iobdc_pkg::HALF_W-1:0] rh;
  logic [iobdc_pkg::HALF_W-1:0] status_rh;

  always_comb begin
    next_q = q;
    // two flops on every pin input; the third stage only feeds the edge detector
    next_q.c1 = ~bus.cmd_lines_n;
    next_q.c2 = q.c1;
    next_q.c3 = q.c2;
    next_q.o1 = bus.select_code_lines_one;
    next_q.z1 = bus.select_code_lines_zero;
    next_q.o2 = q.o1;
    next_q.z2 = q.z1;
    next_q.d1 = bus.bus_data_lines;
    next_q.d2 = q.d1;
    // select has settled long before any command, so the synchronised copy is stable here
    sel_ctl = iobdc_match(DEV_NUM_CTL, q.o2, q.z2);
    sel_dat = iobdc_match(DEV_NUM_DATA, q.o2, q.z2);
    strobe = q.c2 & ~q.c3;
    // one buffered strobe, gated once per device number
    s_ctl = strobe & {iobdc_pkg::CMD_W{sel_ctl}};
    s_dat = strobe & {iobdc_pkg::CMD_W{sel_dat}};
    rh = q.d2[iobdc_pkg::HALF_W-1:0];
    next_q.out_valid = 1'b0;
    next_q.readin_start = 1'b0;

    if (s_ctl[iobdc_pkg::CI_CO_CLR]) begin
      next_q.ctl = '0;
    end
    if (s_ctl[iobdc_pkg::CI_CO_SET]) begin
      next_q.ctl = rh;
      if (rh[iobdc_pkg::CF_CLR_DONE]) begin
        next_q.done = 1'b0;
      end
      if (rh[iobdc_pkg::CF_CLR_ERR]) begin
        next_q.err = 1'b0;
      end
      if (rh[iobdc_pkg::CF_SET_DONE]) begin
        next_q.done = 1'b1;
      end
    end
    if (s_dat[iobdc_pkg::CI_DO_CLR]) begin
      next_q.out_reg = q.d2;
      next_q.busy = 1'b1;
      next_q.done = 1'b0;
    end
    if (s_dat[iobdc_pkg::CI_DO_SET]) begin
      next_q.out_valid = 1'b1;
    end
    if (s_dat[iobdc_pkg::CI_DIN]) begin
      next_q.busy = 1'b1;
      next_q.done = 1'b0;
    end
    if (s_dat[iobdc_pkg::CI_RDI]) begin
      next_q.readin = 1'b1;
      next_q.readin_start = 1'b1;
    end
    // user events come after the command clears so that a set in the same cycle wins; a bus reset in that cycle still clears
    if (out_taken) begin
      next_q.busy = 1'b0;
      next_q.done = 1'b1;
    end
    if (in_ready) begin
      next_q.in_reg = in_word;
      next_q.busy = 1'b0;
      next_q.done = 1'b1;
    end
    if (err_event) begin
      next_q.err = 1'b1;
    end
    // bus reset needs no select: it reaches every device
    if (strobe[iobdc_pkg::CI_RST]) begin
      next_q.ctl = '0;
      next_q.busy = 1'b0;
      next_q.done = 1'b0;
      next_q.err = 1'b0;
      next_q.readin = 1'b0;
    end

    status_rh = '0;
    status_rh[iobdc_pkg::SF_DONE_CH +: iobdc_pkg::CH_W] = q.ctl[iobdc_pkg::CF_DONE_CH +: iobdc_pkg::CH_W];
    status_rh[iobdc_pkg::SF_ERR_CH +: iobdc_pkg::CH_W] = q.ctl[iobdc_pkg::CF_ERR_CH +: iobdc_pkg::CH_W];
    status_rh[iobdc_pkg::SF_DONE] = q.done;
    status_rh[iobdc_pkg::SF_ERR] = q.err;
    status_rh[iobdc_pkg::SF_BUSY] = q.busy;
    status_rh[iobdc_pkg::SF_READIN] = q.readin;
    status_rh[iobdc_pkg::SF_RUN] = q.ctl[iobdc_pkg::CF_RUN];

    // drive only while the selected read level stands; status is gated by the control number, data-in by the data number
    next_q.oe = 1'b0;
    next_q.dout = '0;
    if (q.c2[iobdc_pkg::CI_STAT] && sel_ctl) begin
      next_q.oe = 1'b1;
      next_q.dout = {{iobdc_pkg::HALF_W{1'b0}}, status_rh};
    end else if (q.c2[iobdc_pkg::CI_DIN] && sel_dat) begin
      next_q.oe = 1'b1;
      next_q.dout = q.in_reg;
    end

    // separate decoders so block transfers keep data and error requests apart
    next_q.pi = iobdc_pi_dec(q.ctl[iobdc_pkg::CF_DONE_CH +: iobdc_pkg::CH_W], q.done)
              | iobdc_pi_dec(q.ctl[iobdc_pkg::CF_ERR_CH +: iobdc_pkg::CH_W], q.err);
    next_q.rdi_data = q.done & sel_dat & q.readin;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign bus.dev_dout = q.dout;
  assign bus.dev_oe = q.oe;
  assign bus.pi_request = q.pi;
  assign bus.readin_data = q.rdi_data;
  assign out_word = q.out_reg;
  assign out_valid = q.out_valid;
  assign run = q.ctl[iobdc_pkg::CF_RUN];
  assign readin_start = q.readin_start;
endmodule : iobdc_device

// >>> rtl/iobdc_pkg.sv
// shared constants and types for the parallel i/o bus command port
package iobdc_pkg;
  localparam int DATA_W = 36;
  localparam int SEL_W = 7;
  localparam int PI_W = 7;
  localparam int CH_W = 3;
  localparam int HALF_W = 18;
  localparam int CMD_W = 8;
  // clock and bus timing
  localparam int CLK_NS = 25;
  localparam int SEL_SETUP_NS = 200;
  localparam int SEL_SETUP_CYC = (SEL_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_SETTLE_NS = 1000;
  localparam int DATA_SETTLE_CYC = (DATA_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LEVEL_NS = 2500;
  localparam int LEVEL_CYC = LEVEL_NS / CLK_NS;
  localparam int PULSE_NS = 400;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam int CNT_W = 8;
  // bit positions in the active-low command line vector
  localparam int CI_CO_CLR = 0;
  localparam int CI_CO_SET = 1;
  localparam int CI_DO_CLR = 2;
  localparam int CI_DO_SET = 3;
  localparam int CI_STAT = 4;
  localparam int CI_DIN = 5;
  localparam int CI_RDI = 6;
  localparam int CI_RST = 7;
  localparam logic [CMD_W-1:0] CMD_IDLE_N = 8'hFF;
  // user-built device numbers (7-bit field)
  localparam logic [SEL_W-1:0] USER_DEV_MIN = 7'h40;
  localparam logic [SEL_W-1:0] USER_DEV_MAX = 7'h7F;
  // control word fields, right half of the bus word
  localparam int CF_DONE_CH = 0;
  localparam int CF_ERR_CH = 3;
  localparam int CF_SET_DONE = 6;
  localparam int CF_CLR_DONE = 7;
  localparam int CF_CLR_ERR = 8;
  localparam int CF_RUN = 9;
  // status word fields, right half of the bus word
  localparam int SF_DONE_CH = 0;
  localparam int SF_ERR_CH = 3;
  localparam int SF_DONE = 6;
  localparam int SF_ERR = 7;
  localparam int SF_BUSY = 8;
  localparam int SF_READIN = 9;
  localparam int SF_RUN = 10;
  // host command codes
  typedef enum logic [2:0] {
    OP_CONTROL_OUT, OP_STATUS_IN, OP_DATA_OUT, OP_DATA_IN, OP_READIN, OP_RESET
  } iobdc_op_t;
  // host register map (byte addresses) and fields
  localparam int AV_ADDR_W = 5;
  localparam logic [AV_ADDR_W-1:0] REG_CMD = 5'h00;
  localparam logic [AV_ADDR_W-1:0] REG_WLO = 5'h04;
  localparam logic [AV_ADDR_W-1:0] REG_WHI = 5'h08;
  localparam logic [AV_ADDR_W-1:0] REG_RLO = 5'h0C;
  localparam logic [AV_ADDR_W-1:0] REG_RHI = 5'h10;
  localparam logic [AV_ADDR_W-1:0] REG_STAT = 5'h14;
  localparam int CMDF_OP = 0;
  localparam int CMDF_DEV = 8;
  localparam int STF_BUSY = 0;
  localparam int STF_PI = 1;
  localparam int STF_RDI = 8;
endpackage : iobdc_pkg

// >>> rtl/iobdc_bus_if.sv
// shared i/o bus between the processor end and the device end
interface iobdc_bus_if;
  logic [iobdc_pkg::SEL_W-1:0] select_code_lines_one;
  logic [iobdc_pkg::SEL_W-1:0] select_code_lines_zero;
  logic [iobdc_pkg::CMD_W-1:0] cmd_lines_n;
  logic [iobdc_pkg::DATA_W-1:0] host_dout;
  logic host_oe;
  logic [iobdc_pkg::DATA_W-1:0] dev_dout;
  logic dev_oe;
  logic [iobdc_pkg::DATA_W-1:0] bus_data_lines;
  logic [iobdc_pkg::PI_W-1:0] pi_request;
  logic readin_data;
  // wired-or of all drivers; undriven lines read as zero
  assign bus_data_lines = (host_oe ? host_dout : '0) | (dev_oe ? dev_dout : '0);
  modport host (output select_code_lines_one, output select_code_lines_zero, output cmd_lines_n,
                output host_dout, output host_oe, input bus_data_lines, input pi_request,
                input readin_data);
  modport dev (input select_code_lines_one, input select_code_lines_zero, input cmd_lines_n,
               output dev_dout, output dev_oe, input bus_data_lines, output pi_request,
               output readin_data);
endinterface : iobdc_bus_if

// >>> rtl/iobdc_host.sv
// processor end of the i/o bus, commanded over avalon-mm registers
module iobdc_host (
  input wire logic clk, // 40 mhz
  input wire logic rst_n, // async, active low
  input wire logic [iobdc_pkg::AV_ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  iobdc_bus_if.host bus // device side
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_P1, H_GAP, H_P2, H_LEVEL, H_HOLD} iobdc_hstate_t;

  typedef struct packed {
    iobdc_hstate_t st;
    logic [iobdc_pkg::CNT_W-1:0] cnt;
    logic [2:0] op;
    logic [iobdc_pkg::SEL_W-1:0] dev;
    logic [iobdc_pkg::DATA_W-1:0] wdata;
    logic [iobdc_pkg::DATA_W-1:0] rdata;
    logic [iobdc_pkg::CMD_W-1:0] cmd_n;
    logic oe;
    logic [iobdc_pkg::DATA_W-1:0] d1;
    logic [iobdc_pkg::DATA_W-1:0] d2;
    logic [iobdc_pkg::PI_W-1:0] p1;
    logic [iobdc_pkg::PI_W-1:0] p2;
    logic r1;
    logic r2;
    logic rd_ack;
    logic [31:0] rd;
  } iobdc_host_state_t;

  iobdc_host_state_t q;
  iobdc_host_state_t next_q;
  logic [31:0] rmux;
  logic [iobdc_pkg::CMD_W-1:0] first_n;
  logic [iobdc_pkg::CMD_W-1:0] second_n;
  logic paired;
  logic is_level;

  always_comb begin
    next_q = q;
    next_q.d1 = bus.bus_data_lines;
    next_q.d2 = q.d1;
    next_q.p1 = bus.pi_request;
    next_q.p2 = q.p1;
    next_q.r1 = bus.readin_data;
    next_q.r2 = q.r1;
    first_n = iobdc_pkg::CMD_IDLE_N;
    second_n = iobdc_pkg::CMD_IDLE_N;
    paired = 1'b0;
    is_level = 1'b0;
    unique case (iobdc_pkg::iobdc_op_t'(q.op))
      iobdc_pkg::OP_CONTROL_OUT: begin
        first_n[iobdc_pkg::CI_CO_CLR] = 1'b0;
        second_n[iobdc_pkg::CI_CO_SET] = 1'b0;
        paired = 1'b1;
      end
      iobdc_pkg::OP_DATA_OUT: begin
        first_n[iobdc_pkg::CI_DO_CLR] = 1'b0;
        second_n[iobdc_pkg::CI_DO_SET] = 1'b0;
        paired = 1'b1;
      end
      iobdc_pkg::OP_STATUS_IN: begin
        first_n[iobdc_pkg::CI_STAT] = 1'b0;
        is_level = 1'b1;
      end
      iobdc_pkg::OP_DATA_IN: begin
        first_n[iobdc_pkg::CI_DIN] = 1'b0;
        is_level = 1'b1;
      end
      iobdc_pkg::OP_READIN: first_n[iobdc_pkg::CI_RDI] = 1'b0;
      default: first_n[iobdc_pkg::CI_RST] = 1'b0; // bus reset and undefined codes
    endcase

    if (q.cnt != '0) begin
      next_q.cnt = q.cnt - 1'b1;
    end
    unique case (q.st)
      H_IDLE: begin
        if (avs_write && avs_address == iobdc_pkg::REG_CMD) begin
          next_q.op = avs_writedata[iobdc_pkg::CMDF_OP +: 3];
          next_q.dev = avs_writedata[iobdc_pkg::CMDF_DEV +: iobdc_pkg::SEL_W];
          next_q.st = H_SETUP;
          // data must settle 1 us before the first pulse, which also covers the select setup
          next_q.cnt = iobdc_pkg::CNT_W'(iobdc_pkg::DATA_SETTLE_CYC - 1);
        end
      end
      H_SETUP: begin
        next_q.oe = paired;
        if (q.cnt == '0) begin
          next_q.cmd_n = first_n;
          next_q.st = is_level ? H_LEVEL : H_P1;
          next_q.cnt = is_level ? iobdc_pkg::CNT_W'(iobdc_pkg::LEVEL_CYC - 1)
                                : iobdc_pkg::CNT_W'(iobdc_pkg::PULSE_CYC - 1);
        end
      end
      H_P1, H_P2: begin
        if (q.cnt == '0) begin
          next_q.cmd_n = iobdc_pkg::CMD_IDLE_N;
          next_q.st = (q.st == H_P1 && paired) ? H_GAP : H_HOLD;
          next_q.cnt = iobdc_pkg::CNT_W'(iobdc_pkg::PULSE_CYC - 1);
        end
      end
      H_GAP: begin
        if (q.cnt == '0) begin
          next_q.cmd_n = second_n;
          next_q.st = H_P2;
          next_q.cnt = iobdc_pkg::CNT_W'(iobdc_pkg::PULSE_CYC - 1);
        end
      end
      H_LEVEL: begin
        if (q.cnt == '0) begin
          // sample at the end of the level, after the device and the sync stages have settled
          next_q.rdata = q.d2;
          next_q.cmd_n = iobdc_pkg::CMD_IDLE_N;
          next_q.st = H_HOLD;
          next_q.cnt = iobdc_pkg::CNT_W'(iobdc_pkg::PULSE_CYC - 1);
        end
      end
      H_HOLD: begin
        if (q.cnt == '0) begin
          next_q.oe = 1'b0;
          next_q.st = H_IDLE;
        end
      end
    endcase

    // commands written while a cycle runs are dropped; software polls the busy bit
    if (avs_write && avs_address == iobdc_pkg::REG_WLO) begin
      next_q.wdata[iobdc_pkg::HALF_W-1:0] = avs_writedata[iobdc_pkg::HALF_W-1:0];
    end
    if (avs_write && avs_address == iobdc_pkg::REG_WHI) begin
      next_q.wdata[iobdc_pkg::DATA_W-1:iobdc_pkg::HALF_W] = avs_writedata[iobdc_pkg::HALF_W-1:0];
    end

    rmux = '0;
    unique case (avs_address)
      iobdc_pkg::REG_CMD: begin
        rmux[iobdc_pkg::CMDF_OP +: 3] = q.op;
        rmux[iobdc_pkg::CMDF_DEV +: iobdc_pkg::SEL_W] = q.dev;
      end
      iobdc_pkg::REG_WLO: rmux[iobdc_pkg::HALF_W-1:0] = q.wdata[iobdc_pkg::HALF_W-1:0];
      iobdc_pkg::REG_WHI: rmux[iobdc_pkg::HALF_W-1:0] = q.wdata[iobdc_pkg::DATA_W-1:iobdc_pkg::HALF_W];
      iobdc_pkg::REG_RLO: rmux[iobdc_pkg::HALF_W-1:0] = q.rdata[iobdc_pkg::HALF_W-1:0];
      iobdc_pkg::REG_RHI: rmux[iobdc_pkg::HALF_W-1:0] = q.rdata[iobdc_pkg::DATA_W-1:iobdc_pkg::HALF_W];
      iobdc_pkg::REG_STAT: begin
        rmux[iobdc_pkg::STF_BUSY] = (q.st != H_IDLE);
        rmux[iobdc_pkg::STF_PI +: iobdc_pkg::PI_W] = q.p2;
        rmux[iobdc_pkg::STF_RDI] = q.r2;
      end
      default: rmux = '0;
    endcase
    next_q.rd_ack = avs_read & ~q.rd_ack;
    if (avs_read && !q.rd_ack) begin
      next_q.rd = rmux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cmd_n <= iobdc_pkg::CMD_IDLE_N;
    end else begin
      q <= next_q;
    end
  end

  assign avs_waitrequest = avs_read & ~q.rd_ack;
  assign avs_readdata = q.rd;
  assign bus.select_code_lines_one = q.dev;
  assign bus.select_code_lines_zero = ~q.dev;
  assign bus.cmd_lines_n = q.cmd_n;
  assign bus.host_dout = {q.wdata[iobdc_pkg::DATA_W-1:iobdc_pkg::HALF_W], q.wdata[iobdc_pkg::HALF_W-1:0]};
  assign bus.host_oe = q.oe;
endmodule : iobdc_host

// >>> test/iobdc_bus_assertions.sv
// bus-level checks on the shared i/o bus between the processor end and the device end
module iobdc_bus_assertions #(
  parameter logic [iobdc_pkg::SEL_W-1:0] DEV_NUM_CTL = 7'h40, // control/status number
  parameter logic [iobdc_pkg::SEL_W-1:0] DEV_NUM_DATA = 7'h41 // data number
) (
  input wire logic clk, // bus clock
  input wire logic rst_n, // async, active low
  input wire logic [iobdc_pkg::SEL_W-1:0] select_code_lines_one, // true select lines
  input wire logic [iobdc_pkg::SEL_W-1:0] select_code_lines_zero, // complement select lines
  input wire logic [iobdc_pkg::CMD_W-1:0] cmd_lines_n, // active-low commands
  input wire logic host_oe, // processor drives data
  input wire logic dev_oe, // device drives data
  input wire logic [iobdc_pkg::PI_W-1:0] pi_request, // interrupt lines
  input wire logic readin_data // read-in word ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel_ctl;
  logic sel_dat;
  logic drive_ok;
  logic [7:0] low_cnt;
  // both rails of every pair must agree, a half-driven code selects nothing
  assign sel_ctl = (select_code_lines_one == DEV_NUM_CTL) && (select_code_lines_zero == ~DEV_NUM_CTL);
  assign sel_dat = (select_code_lines_one == DEV_NUM_DATA) && (select_code_lines_zero == ~DEV_NUM_DATA);
  assign drive_ok = (!cmd_lines_n[4] && sel_ctl) || (!cmd_lines_n[5] && sel_dat);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= (&cmd_lines_n[6:0]) ? 8'h00 : low_cnt + 8'h01;
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the device lags the level by its synchroniser, so allow two to four cycles
  property p_drive_cause;
    dev_oe |-> $past(drive_ok, 2) || $past(drive_ok, 3) || $past(drive_ok, 4);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("device drove data unselected");
  property p_drive_resp;
    drive_ok [*5] |-> dev_oe;
  endproperty
  a_drive_resp: assert property (p_drive_resp) else $error("device silent during read level");
  property p_one_driver;
    !(host_oe && dev_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
  property p_co_order;
    $fell(cmd_lines_n[0]) |-> ##[30:34] $fell(cmd_lines_n[1]);
  endproperty
  a_co_order: assert property (p_co_order) else $error("control set pulse missing");
  property p_do_order;
    $fell(cmd_lines_n[2]) |-> ##[30:34] $fell(cmd_lines_n[3]);
  endproperty
  a_do_order: assert property (p_do_order) else $error("data set pulse missing");
  property p_sel_setup;
    $fell(&cmd_lines_n[6:0]) |->
      $past({select_code_lines_one, select_code_lines_zero}, 8) == {select_code_lines_one, select_code_lines_zero};
  endproperty
  a_sel_setup: assert property (p_sel_setup) else $error("select moved before command");
  property p_width;
    $rose(&cmd_lines_n[6:0]) |-> low_cnt == ((&$past(cmd_lines_n[5:4])) ? 8'h10 : 8'h64);
  endproperty
  a_width: assert property (p_width) else $error("command width wrong");
  property p_reset;
    (!cmd_lines_n[7]) [*8] |-> (pi_request == 7'h00) && !readin_data;
  endproperty
  a_reset: assert property (p_reset) else $error("bus reset left a request");
  property p_pi_pair;
    $countones(pi_request) <= 2;
  endproperty
  a_pi_pair: assert property (p_pi_pair) else $error("more lines than channels");
endmodule : iobdc_bus_assertions

// >>> test/tb_top.sv
// self-checking bench: processor end and device end joined on the shared bus
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [35:0] out_word;
  logic out_valid;
  logic out_taken = 1'b0;
  logic [35:0] in_word = 36'h0;
  logic in_ready = 1'b0;
  logic err_event = 1'b0;
  logic run;
  logic readin_start;
  int num_errors = 0;
  int checks_done = 0;
  int rs_n = 0;
  logic [63:0] rq[$];
  logic [35:0] oq[$];
  logic [63:0] r;
  logic [35:0] w;
  logic [31:0] q;
  logic [6:0] dv;
  iobdc_bus_if bus();
  iobdc_host iobdc_host_i (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
                           .avs_waitrequest, .bus(bus));
  iobdc_device iobdc_device_i (.clk, .rst_n, .bus(bus), .out_word, .out_valid, .out_taken, .in_word, .in_ready,
                               .err_event, .run, .readin_start);
  iobdc_bus_assertions #(.DEV_NUM_CTL(7'h40), .DEV_NUM_DATA(7'h41)) iobdc_bus_assertions_i (.clk, .rst_n,
    .select_code_lines_one(bus.select_code_lines_one), .select_code_lines_zero(bus.select_code_lines_zero),
    .cmd_lines_n(bus.cmd_lines_n), .host_oe(bus.host_oe), .dev_oe(bus.dev_oe), .pi_request(bus.pi_request),
    .readin_data(bus.readin_data));
  always #12.5 clk = ~clk;
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic tmo();
    num_errors++;
    $display("[FAIL] %0t: wait timed out", $time);
    print_verdict();
  endtask : tmo
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  // one avalon transfer; a read notes its masked expectation for the monitor
  task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] dt, m, e);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= dt;
    avs_read <= rd;
    avs_write <= !rd;
    if (rd) rq.push_back({m, e});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) tmo();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic io(input iobdc_pkg::iobdc_op_t op, input logic [6:0] d, input logic [35:0] wd);
    int n;
    av(1'b0, iobdc_pkg::REG_WLO, {14'h0, wd[17:0]}, 32'h0, 32'h0);
    av(1'b0, iobdc_pkg::REG_WHI, {14'h0, wd[35:18]}, 32'h0, 32'h0);
    av(1'b0, iobdc_pkg::REG_CMD, {17'h0, d, 5'h0, op}, 32'h0, 32'h0);
    n = 0;
    do begin
      av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'h0, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 300);
    if (q[0] !== 1'b0) tmo();
  endtask : io
  task automatic rdw(input logic [35:0] e, m);
    av(1'b1, iobdc_pkg::REG_RLO, 32'h0, {14'h0, m[17:0]}, {14'h0, e[17:0]});
    av(1'b1, iobdc_pkg::REG_RHI, 32'h0, {14'h0, m[35:18]}, {14'h0, e[35:18]});
  endtask : rdw
  task automatic st(input logic [6:0] d, input logic [35:0] e, m);
    io(iobdc_pkg::OP_STATUS_IN, d, 36'h0);
    rdw(e, m);
  endtask : st
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      r = rq.pop_front();
      if (r[63:32] != 32'h0) chk(36'(avs_readdata & r[63:32]), 36'(r[31:0]));
    end
    if (out_valid === 1'b1) begin
      if (oq.size() > 0) chk(out_word, oq.pop_front());
      else chk(36'h1, 36'h0);
    end
    if (readin_start === 1'b1) rs_n++;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(70));
    av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'h1FF, 32'h0);
    av(1'b1, 5'h18, 32'h0, 32'hFFFFFFFF, 32'h0);
    av(1'b0, 5'h18, 32'h12345, 32'h0, 32'h0);
    fin("reset");
    // done channel 3, error channel 5, set done, run; copy in both halves
    io(iobdc_pkg::OP_CONTROL_OUT, 7'h40, {2{18'h0026B}});
    chk(36'(run), 36'h1);
    av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'hFE, 32'h8);
    st(7'h40, 36'h46B, '1);
    @(posedge clk) err_event <= 1'b1;
    @(posedge clk) err_event <= 1'b0;
    repeat (4) @(posedge clk);
    av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'hFE, 32'h28);
    st(7'h40, 36'h4EB, '1);
    fin("control");
    io(iobdc_pkg::OP_CONTROL_OUT, 7'h40, {2{18'h00180}});
    chk(36'(run), 36'h0);
    st(7'h40, 36'h0, '1);
    io(iobdc_pkg::OP_CONTROL_OUT, 7'h40, {2{18'h00040}});
    av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'hFE, 32'h0);
    st(7'h40, 36'h40, '1);
    fin("channel zero");
    repeat (3) begin
      dv = 7'h42 + 7'($urandom % 62);
      io(iobdc_pkg::OP_CONTROL_OUT, dv, {2{18'h00200}});
      chk(36'(run), 36'h0);
      st(dv, 36'h0, '1);
    end
    fin("unselected");
    repeat (2) begin
      w = 36'({$urandom, $urandom});
      oq.push_back(w);
      io(iobdc_pkg::OP_DATA_OUT, 7'h41, w);
      st(7'h40, 36'h100, '1);
    end
    @(posedge clk) out_taken <= 1'b1;
    @(posedge clk) out_taken <= 1'b0;
    repeat (4) @(posedge clk);
    st(7'h40, 36'h40, '1);
    fin("data out");
    w = 36'({$urandom, $urandom});
    @(posedge clk) in_ready <= 1'b1;
    in_word <= w;
    @(posedge clk) in_ready <= 1'b0;
    repeat (4) @(posedge clk);
    io(iobdc_pkg::OP_DATA_IN, 7'h41, 36'h0);
    rdw(w, '1);
    st(7'h40, 36'h100, '1);
    fin("data in");
    // done on channel 3 so that the bus reset has a live request to clear
    io(iobdc_pkg::OP_CONTROL_OUT, 7'h40, {2{18'h00043}});
    av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'hFE, 32'h8);
    io(iobdc_pkg::OP_RESET, 7'h00, 36'h0);
    av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'hFE, 32'h0);
    st(7'h40, 36'h0, '1);
    io(iobdc_pkg::OP_READIN, 7'h41, 36'h0);
    // a ready word in read-in mode, still selected, must show on the read-in data line
    @(posedge clk) in_ready <= 1'b1;
    @(posedge clk) in_ready <= 1'b0;
    repeat (4) @(posedge clk);
    av(1'b1, iobdc_pkg::REG_STAT, 32'h0, 32'h100, 32'h100);
    st(7'h40, 36'h200, 36'h200);
    chk(36'(rs_n), 36'h1);
    chk(36'(oq.size()), 36'h0);
    fin("read-in");
    print_verdict();
  end
endmodule : tb_top
